// ### hw/dsp_io_pkg.sv
package dsp_io_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int IN_W   = 20;
  localparam int OUT_W  = 16;
  localparam int ERR_W  = 4;
  localparam int DIR_W  = 4;
  localparam int SYNC_W = 5;

  // ----------------------------------------------------------------
  // Read word bit positions
  // ----------------------------------------------------------------
  localparam int RD_TIMER_START  = 19;
  localparam int RD_TRUE         = 18;
  localparam int RD_IRQ_BG_N     = 17;
  localparam int RD_CAP_BG_N     = 16;
  localparam int RD_EXT_COMP_N   = 15;
  localparam int RD_INT_COMP_N   = 14;
  localparam int RD_SINGLE       = 13;
  localparam int RD_GROUNDED     = 12;
  localparam int RD_OVFL_ERR_N   = 11;
  localparam int RD_COMB_ERR_N   = 10;
  localparam int RD_FE_ACTIVE_N  = 9;
  localparam int RD_RES_RD_BUSY  = 8;
  localparam int RD_NVRAM_BUSY   = 7;
  localparam int RD_IRQ_PIN      = 6;
  localparam int RD_TEMP_ERR_N   = 5;
  localparam int RD_RES_BUSY     = 4;
  localparam int RD_GPIO_THREE   = 3;
  localparam int RD_GPIO_TWO     = 2;
  localparam int RD_GPIO_ONE     = 1;
  localparam int RD_GPIO_ZERO    = 0;

  // ----------------------------------------------------------------
  // Write word bit positions
  // ----------------------------------------------------------------
  localparam int WR_BANDGAP      = 15;
  localparam int WR_MEM_PUSH     = 14;
  localparam int WR_CAP_RESET    = 13;
  localparam int WR_MEM_READ     = 12;
  localparam int WR_IRQ          = 11;
  localparam int WR_PAGE         = 10;
  localparam int WR_RES_START    = 9;
  localparam int WR_CAP_START    = 8;
  localparam int WR_GUARD_HI     = 7;
  localparam int WR_GUARD_LO     = 6;
  localparam int WR_GPIO_FIVE    = 5;
  localparam int WR_GPIO_FOUR    = 4;
  localparam int WR_GPIO_THREE   = 3;
  localparam int WR_GPIO_TWO     = 2;
  localparam int WR_GPIO_ONE     = 1;
  localparam int WR_GPIO_ZERO    = 0;

  // ----------------------------------------------------------------
  // Synchroniser lanes
  // ----------------------------------------------------------------
  localparam int SY_GPIO_ZERO  = 0;
  localparam int SY_GPIO_ONE   = 1;
  localparam int SY_GPIO_TWO   = 2;
  localparam int SY_GPIO_THREE = 3;
  localparam int SY_SSN        = 4;

  // ----------------------------------------------------------------
  // Guard patterns on write bits 7:6
  // ----------------------------------------------------------------
  localparam logic [1:0] GUARD_IDLE    = 2'h0;
  localparam logic [1:0] GUARD_ARM_WD  = 2'h1;
  localparam logic [1:0] GUARD_ARM_INI = 2'h2;
  localparam logic [1:0] GUARD_FIRE    = 2'h3;

  typedef enum logic [1:0] {
    G_IDLE,
    G_ARMED_WD,
    G_ARMED_INI
  } guard_state_type;

endpackage : dsp_io_pkg

// ### hw/dsp_io_status_control_port.sv
`timescale 1ns/100ps
module dsp_io_status_control_port (
  input  wire logic                         sys_clk,
  input  wire logic                         rst,
  input  wire logic                         clk_en,
  // DSP access
  input  wire logic                         dsp_out_wr,
  input  wire logic [dsp_io_pkg::OUT_W-1:0] dsp_out_data,
  output logic      [dsp_io_pkg::IN_W-1:0]  dsp_in_word,
  // Status and configuration, same clock
  input  wire logic                         timer_start_input,
  input  wire logic                         irq_bandgap_trigger_cfg_n,
  input  wire logic                         cap_bandgap_trigger_cfg_n,
  input  wire logic                         external_compensation_cfg_n,
  input  wire logic                         internal_compensation_cfg_n,
  input  wire logic                         single_ended_cfg,
  input  wire logic                         grounded_cfg,
  input  wire logic                         converter_overflow_err_n,
  input  wire logic [dsp_io_pkg::ERR_W-1:0] converter_error_flags,
  input  wire logic                         frontend_active,
  input  wire logic                         result_read_busy,
  input  wire logic                         nvram_busy,
  input  wire logic                         temperature_error_n,
  input  wire logic                         resistance_meas_busy,
  input  wire logic                         cap_meas_done,
  input  wire logic                         i2c_stop,
  input  wire logic                         irq_on_gpio_four_en,
  input  wire logic                         irq_on_gpio_five_en,
  input  wire logic [dsp_io_pkg::DIR_W-1:0] gpio_dir_in,
  input  wire logic                         pulse_out_zero,
  input  wire logic                         pulse_out_zero_on,
  input  wire logic                         pulse_out_one,
  input  wire logic                         pulse_out_one_on,
  // Pins
  input  wire logic                         spi_ssn,
  input  wire logic                         port_gpio_zero_in,
  output logic                              port_gpio_zero_out,
  output logic                              port_gpio_zero_oe,
  input  wire logic                         port_gpio_one_in,
  output logic                              port_gpio_one_out,
  output logic                              port_gpio_one_oe,
  input  wire logic                         port_gpio_two_in,
  output logic                              port_gpio_two_out,
  output logic                              port_gpio_two_oe,
  input  wire logic                         port_gpio_three_in,
  output logic                              port_gpio_three_out,
  output logic                              port_gpio_three_oe,
  output logic                              port_gpio_four,
  output logic                              port_gpio_five,
  output logic                              interrupt_pin_n,
  // Triggers to the measurement hardware
  output logic                              bandgap_start_pulse,
  output logic                              cap_converter_reset,
  output logic                              resistance_meas_start,
  output logic                              cap_meas_start,
  output logic                              cap_meas_blocked,
  output logic                              watchdog_restart,
  output logic                              init_reset
);
  import dsp_io_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic wr_bit(input logic wr, input logic [OUT_W-1:0] d, input int idx);
    wr_bit = wr & d[idx];
  endfunction : wr_bit

  function automatic logic pin_mux(input logic level, input logic pulse_on,
                                   input logic pulse);
    pin_mux = pulse_on ? (level | pulse) : level;
  endfunction : pin_mux

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] pins_async;
  logic [SYNC_W-1:0] pins_sync;

  assign pins_async[SY_GPIO_ZERO]  = port_gpio_zero_in;
  assign pins_async[SY_GPIO_ONE]   = port_gpio_one_in;
  assign pins_async[SY_GPIO_TWO]   = port_gpio_two_in;
  assign pins_async[SY_GPIO_THREE] = port_gpio_three_in;
  assign pins_async[SY_SSN]        = spi_ssn;

  sync_two_ff u_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .async_in (pins_async),
    .sync_out (pins_sync)
  );

  // ----------------------------------------------------------------
  // Watchdog and init guard
  // ----------------------------------------------------------------
  guard_pattern_seq u_guard (
    .sys_clk          (sys_clk),
    .rst              (rst),
    .clk_en           (clk_en),
    .wr               (dsp_out_wr),
    .pattern          (dsp_out_data[WR_GUARD_HI:WR_GUARD_LO]),
    .watchdog_restart (watchdog_restart),
    .init_reset       (init_reset)
  );

  // ----------------------------------------------------------------
  // Output latches and self-clearing pulses
  // ----------------------------------------------------------------
  logic       bandgap_r;
  logic       bandgap_nxt;
  logic       cap_rst_r;
  logic       cap_rst_nxt;
  logic       res_start_r;
  logic       res_start_nxt;
  logic       cap_start_r;
  logic       cap_start_nxt;
  logic       need_rst_r;
  logic       need_rst_nxt;
  logic       irq_r;
  logic       irq_nxt;
  logic       ssn_d_r;
  logic       ssn_d_nxt;
  logic [5:0] gpio_r;
  logic [5:0] gpio_nxt;
  logic       ssn_rise;
  logic       irq_clear;
  logic       irq_set;

  assign ssn_rise  = pins_sync[SY_SSN] & ~ssn_d_r;
  assign irq_clear = ssn_rise | i2c_stop;
  assign irq_set   = wr_bit(dsp_out_wr, dsp_out_data, WR_IRQ);

  always_comb begin
    bandgap_nxt   = bandgap_r;
    cap_rst_nxt   = cap_rst_r;
    res_start_nxt = res_start_r;
    cap_start_nxt = cap_start_r;
    need_rst_nxt  = need_rst_r;
    irq_nxt       = irq_r;
    ssn_d_nxt     = ssn_d_r;
    gpio_nxt      = gpio_r;
    if (clk_en) begin
      // Bits 14, 12 and 10 belong to ROM routines and are not decoded
      bandgap_nxt   = wr_bit(dsp_out_wr, dsp_out_data, WR_BANDGAP);
      cap_rst_nxt   = wr_bit(dsp_out_wr, dsp_out_data, WR_CAP_RESET);
      res_start_nxt = wr_bit(dsp_out_wr, dsp_out_data, WR_RES_START);
      cap_start_nxt = wr_bit(dsp_out_wr, dsp_out_data, WR_CAP_START)
                      & ~need_rst_r;
      // Done sets over a reset write in the same cycle
      if (cap_meas_done) need_rst_nxt = 1'b1;
      else if (wr_bit(dsp_out_wr, dsp_out_data, WR_CAP_RESET)) need_rst_nxt = 1'b0;
      // Set wins over clear
      if (irq_set) irq_nxt = 1'b1;
      else if (irq_clear) irq_nxt = 1'b0;
      ssn_d_nxt = pins_sync[SY_SSN];
      if (dsp_out_wr) begin
        gpio_nxt = dsp_out_data[WR_GPIO_FIVE:WR_GPIO_ZERO];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bandgap_r   <= 1'b0;
      cap_rst_r   <= 1'b0;
      res_start_r <= 1'b0;
      cap_start_r <= 1'b0;
      need_rst_r  <= 1'b0;
      irq_r       <= 1'b0;
      ssn_d_r     <= 1'b1;
      gpio_r      <= '0;
    end else begin
      bandgap_r   <= bandgap_nxt;
      cap_rst_r   <= cap_rst_nxt;
      res_start_r <= res_start_nxt;
      cap_start_r <= cap_start_nxt;
      need_rst_r  <= need_rst_nxt;
      irq_r       <= irq_nxt;
      ssn_d_r     <= ssn_d_nxt;
      gpio_r      <= gpio_nxt;
    end
  end

  assign bandgap_start_pulse   = bandgap_r;
  assign cap_converter_reset   = cap_rst_r;
  assign resistance_meas_start = res_start_r;
  assign cap_meas_start        = cap_start_r;
  assign cap_meas_blocked      = need_rst_r;

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  assign interrupt_pin_n     = ~irq_r;
  assign port_gpio_zero_out  = gpio_r[WR_GPIO_ZERO];
  assign port_gpio_zero_oe   = ~gpio_dir_in[SY_GPIO_ZERO];
  assign port_gpio_one_out   = gpio_r[WR_GPIO_ONE];
  assign port_gpio_one_oe    = ~gpio_dir_in[SY_GPIO_ONE];
  assign port_gpio_two_out   = pin_mux(gpio_r[WR_GPIO_TWO], pulse_out_zero_on,
                                       pulse_out_zero);
  assign port_gpio_two_oe    = ~gpio_dir_in[SY_GPIO_TWO];
  assign port_gpio_three_out = pin_mux(gpio_r[WR_GPIO_THREE], pulse_out_one_on,
                                       pulse_out_one);
  assign port_gpio_three_oe  = ~gpio_dir_in[SY_GPIO_THREE];
  assign port_gpio_four      = irq_on_gpio_four_en ? ~irq_r : gpio_r[WR_GPIO_FOUR];
  assign port_gpio_five      = irq_on_gpio_five_en ? ~irq_r : gpio_r[WR_GPIO_FIVE];

  // ----------------------------------------------------------------
  // Read word
  // ----------------------------------------------------------------
  logic [IN_W-1:0] rd_r;
  logic [IN_W-1:0] rd_nxt;

  always_comb begin
    rd_nxt = rd_r;
    if (clk_en) begin
      rd_nxt[RD_TIMER_START] = timer_start_input;
      rd_nxt[RD_TRUE]        = 1'b1;
      rd_nxt[RD_IRQ_BG_N]    = irq_bandgap_trigger_cfg_n;
      rd_nxt[RD_CAP_BG_N]    = cap_bandgap_trigger_cfg_n;
      rd_nxt[RD_EXT_COMP_N]  = external_compensation_cfg_n;
      rd_nxt[RD_INT_COMP_N]  = internal_compensation_cfg_n;
      rd_nxt[RD_SINGLE]      = single_ended_cfg;
      rd_nxt[RD_GROUNDED]    = grounded_cfg;
      rd_nxt[RD_OVFL_ERR_N]  = converter_overflow_err_n;
      rd_nxt[RD_COMB_ERR_N]  = ~(|converter_error_flags) & converter_overflow_err_n;
      rd_nxt[RD_FE_ACTIVE_N] = ~frontend_active;
      rd_nxt[RD_RES_RD_BUSY] = result_read_busy;
      rd_nxt[RD_NVRAM_BUSY]  = nvram_busy;
      rd_nxt[RD_IRQ_PIN]     = ~irq_r;
      rd_nxt[RD_TEMP_ERR_N]  = temperature_error_n;
      rd_nxt[RD_RES_BUSY]    = resistance_meas_busy;
      rd_nxt[RD_GPIO_THREE]  = pins_sync[SY_GPIO_THREE];
      rd_nxt[RD_GPIO_TWO]    = pins_sync[SY_GPIO_TWO];
      rd_nxt[RD_GPIO_ONE]    = pins_sync[SY_GPIO_ONE];
      rd_nxt[RD_GPIO_ZERO]   = pins_sync[SY_GPIO_ZERO];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_r <= '0;
    end else begin
      rd_r <= rd_nxt;
    end
  end

  assign dsp_in_word = rd_r;

endmodule : dsp_io_status_control_port

// ### hw/guard_pattern_seq.sv
`timescale 1ns/100ps
module guard_pattern_seq (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       clk_en,
  input  wire logic       wr,
  input  wire logic [1:0] pattern,
  output logic            watchdog_restart,
  output logic            init_reset
);
  import dsp_io_pkg::*;

  guard_state_type state_r;
  guard_state_type state_nxt;
  logic            wd_r;
  logic            wd_nxt;
  logic            ini_r;
  logic            ini_nxt;

  // ----------------------------------------------------------------
  // Arm with one pattern, fire with the next nonzero one; any other nonzero pattern disarms
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    wd_nxt    = wd_r;
    ini_nxt   = ini_r;
    if (clk_en) begin
      wd_nxt  = 1'b0;
      ini_nxt = 1'b0;
      if (wr && (pattern != GUARD_IDLE)) begin
        case (state_r)
          G_IDLE: begin
            if (pattern == GUARD_ARM_WD) state_nxt = G_ARMED_WD;
            else if (pattern == GUARD_ARM_INI) state_nxt = G_ARMED_INI;
            else state_nxt = G_IDLE;
          end
          G_ARMED_WD: begin
            wd_nxt    = (pattern == GUARD_FIRE);
            state_nxt = G_IDLE;
          end
          G_ARMED_INI: begin
            ini_nxt   = (pattern == GUARD_FIRE);
            state_nxt = G_IDLE;
          end
          default: state_nxt = G_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= G_IDLE;
      wd_r    <= 1'b0;
      ini_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      wd_r    <= wd_nxt;
      ini_r   <= ini_nxt;
    end
  end

  assign watchdog_restart = wd_r;
  assign init_reset       = ini_r;

endmodule : guard_pattern_seq

// ### hw/sync_two_ff.sv
`timescale 1ns/100ps
module sync_two_ff (
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  input  wire logic                     clk_en,
  input  wire logic [dsp_io_pkg::SYNC_W-1:0] async_in,
  output logic      [dsp_io_pkg::SYNC_W-1:0] sync_out
);
  import dsp_io_pkg::*;
  localparam logic [SYNC_W-1:0] SSN_IDLE = SYNC_W'(1) << SY_SSN;
  logic [SYNC_W-1:0] meta_r;
  logic [SYNC_W-1:0] meta_nxt;
  logic [SYNC_W-1:0] sync_r;
  logic [SYNC_W-1:0] sync_nxt;

  always_comb begin
    meta_nxt = meta_r;
    sync_nxt = sync_r;
    if (clk_en) begin
      meta_nxt = async_in;
      sync_nxt = meta_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_r <= SSN_IDLE;
      sync_r <= SSN_IDLE;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;

endmodule : sync_two_ff

// ### sim/dsp_fw_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Firmware side: one output write per request
// ----------------------------------------------------------------
module dsp_fw_model (
  input  wire logic                         sys_clk,
  input  wire logic                         req,
  input  wire logic [dsp_io_pkg::OUT_W-1:0] req_data,
  input  wire logic                         pulse_out_zero_on,
  input  wire logic                         pulse_out_one_on,
  output logic                              dsp_out_wr,
  output logic      [dsp_io_pkg::OUT_W-1:0] dsp_out_data
);
  import dsp_io_pkg::*;
  logic [OUT_W-1:0] word_nxt;

  always_comb begin
    word_nxt = req_data;
    word_nxt[WR_MEM_PUSH] = 1'b0;
    word_nxt[WR_MEM_READ] = 1'b0;
    word_nxt[WR_PAGE] = 1'b0;
    if (pulse_out_zero_on) begin
      word_nxt[WR_GPIO_TWO] = 1'b0;
    end
    if (pulse_out_one_on) begin
      word_nxt[WR_GPIO_THREE] = 1'b0;
    end
  end

  // Data is not held between writes
  always_ff @(posedge sys_clk) begin
    dsp_out_wr   <= req;
    dsp_out_data <= req ? word_nxt : ~dsp_out_data;
  end
endmodule : dsp_fw_model

// ### sim/dsp_io_port_props.sv
`timescale 1ns/100ps
module dsp_io_port_props (
  input wire logic                         sys_clk,
  input wire logic                         rst,
  input wire logic                         clk_en,
  input wire logic                         dsp_out_wr,
  input wire logic [dsp_io_pkg::OUT_W-1:0] dsp_out_data,
  input wire logic [dsp_io_pkg::IN_W-1:0]  dsp_in_word,
  input wire logic                         converter_overflow_err_n,
  input wire logic [dsp_io_pkg::ERR_W-1:0] converter_error_flags,
  input wire logic                         frontend_active,
  input wire logic                         nvram_busy,
  input wire logic                         cap_meas_done,
  input wire logic                         i2c_stop,
  input wire logic                         irq_on_gpio_four_en,
  input wire logic                         pulse_out_zero,
  input wire logic                         pulse_out_zero_on,
  input wire logic                         port_gpio_two_out,
  input wire logic                         port_gpio_four,
  input wire logic                         interrupt_pin_n,
  input wire logic                         bandgap_start_pulse,
  input wire logic                         cap_converter_reset,
  input wire logic                         resistance_meas_start,
  input wire logic                         cap_meas_start,
  input wire logic                         cap_meas_blocked,
  input wire logic                         watchdog_restart,
  input wire logic                         init_reset
);
  import dsp_io_pkg::*;
  logic [3:0] trig;
  logic       comb_exp;
  logic       fire_wr;
  logic       set_wr;

  assign trig = {4{dsp_out_wr}} & {dsp_out_data[WR_BANDGAP], dsp_out_data[WR_CAP_RESET],
                                   dsp_out_data[WR_RES_START], dsp_out_data[WR_CAP_START]};
  assign comb_exp = ~(|converter_error_flags) & converter_overflow_err_n;
  assign fire_wr = dsp_out_wr && (dsp_out_data[WR_GUARD_HI:WR_GUARD_LO] == GUARD_FIRE);
  assign set_wr = dsp_out_wr & dsp_out_data[WR_IRQ];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst || !clk_en);

  a_true_const: assert property (!$past(rst) |-> dsp_in_word[RD_TRUE])
    else $error("true bit low");
  a_overflow_mirror: assert property (!$past(rst) |->
    dsp_in_word[RD_OVFL_ERR_N] == $past(converter_overflow_err_n))
    else $error("overflow bit wrong");
  a_comb_error: assert property (!$past(rst) |-> dsp_in_word[RD_COMB_ERR_N] == $past(comb_exp))
    else $error("combined error bit wrong");
  a_frontend_inv: assert property (!$past(rst) |->
    dsp_in_word[RD_FE_ACTIVE_N] != $past(frontend_active))
    else $error("frontend bit wrong");
  a_nvram_busy: assert property (!$past(rst) |-> dsp_in_word[RD_NVRAM_BUSY] == $past(nvram_busy))
    else $error("memory busy bit wrong");
  a_irq_level: assert property (!$past(rst) |-> dsp_in_word[RD_IRQ_PIN] == $past(interrupt_pin_n))
    else $error("interrupt read bit wrong");
  a_irq_clear: assert property (i2c_stop && !set_wr |=> interrupt_pin_n)
    else $error("interrupt not cleared");
  a_irq_set: assert property (set_wr |=> !interrupt_pin_n)
    else $error("interrupt not set");
  a_trigger_pulses: assert property (!$past(rst) |-> {bandgap_start_pulse, cap_converter_reset,
    resistance_meas_start, cap_meas_start} == ($past(trig) & {3'h7, !$past(cap_meas_blocked)}))
    else $error("trigger pulse wrong");
  a_cap_lockout: assert property (cap_meas_done |=> cap_meas_blocked)
    else $error("lockout not set");
  a_guard_fire: assert property (watchdog_restart || init_reset |-> $past(fire_wr))
    else $error("guard action without fire pattern");
  a_pulse_passes: assert property (pulse_out_zero_on && pulse_out_zero |-> port_gpio_two_out)
    else $error("pulse missing on pin two");
  a_irq_route: assert property (irq_on_gpio_four_en |-> port_gpio_four == interrupt_pin_n)
    else $error("interrupt not routed to pin four");

  c_watchdog: cover property (watchdog_restart);
  c_refused: cover property (cap_meas_blocked && trig[0]);
  c_irq_clear: cover property (i2c_stop && !interrupt_pin_n);
endmodule : dsp_io_port_props

bind dsp_io_status_control_port dsp_io_port_props props (.*);

// ### sim/tb_dsp_io_status_control_port.sv
`timescale 1ns/100ps
module tb_dsp_io_status_control_port;
  import dsp_io_pkg::*;
  logic sys_clk, rst, clk_en, dsp_out_wr, req;
  logic [OUT_W-1:0] dsp_out_data, req_data;
  logic [IN_W-1:0] dsp_in_word;
  logic [ERR_W-1:0] converter_error_flags;
  logic [DIR_W-1:0] gpio_dir_in;
  logic timer_start_input, irq_bandgap_trigger_cfg_n, cap_bandgap_trigger_cfg_n;
  logic external_compensation_cfg_n, internal_compensation_cfg_n, single_ended_cfg;
  logic grounded_cfg, converter_overflow_err_n, frontend_active, result_read_busy;
  logic nvram_busy, temperature_error_n, resistance_meas_busy, cap_meas_done, i2c_stop;
  logic irq_on_gpio_four_en, irq_on_gpio_five_en, pulse_out_zero, pulse_out_zero_on;
  logic pulse_out_one, pulse_out_one_on, spi_ssn, port_gpio_zero_in, port_gpio_one_in;
  logic port_gpio_two_in, port_gpio_three_in, port_gpio_zero_out, port_gpio_zero_oe;
  logic port_gpio_one_out, port_gpio_one_oe, port_gpio_two_out, port_gpio_two_oe;
  logic port_gpio_three_out, port_gpio_three_oe, port_gpio_four, port_gpio_five;
  logic interrupt_pin_n, bandgap_start_pulse, cap_converter_reset, resistance_meas_start;
  logic cap_meas_start, cap_meas_blocked, watchdog_restart, init_reset;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;

  dsp_io_status_control_port dut (.*);
  dsp_fw_model fw (.sys_clk, .req, .req_data, .pulse_out_zero_on, .pulse_out_one_on,
                   .dsp_out_wr, .dsp_out_data);

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails = fails + 1;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [19:0] got, input logic [19:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  // Returns just after the edge that takes the write
  task automatic wr(input logic [15:0] d);
    @(posedge sys_clk);
    req <= 1'b1;
    req_data <= d;
    @(posedge sys_clk);
    req <= 1'b0;
    tick(1);
  endtask : wr

  task automatic report_and_stop();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_status();
    logic v;
    logic [15:0] e;
    for (int i = 0; i < 3; i++) begin
      v = i[0];
      @(posedge sys_clk);
      {timer_start_input, irq_bandgap_trigger_cfg_n, cap_bandgap_trigger_cfg_n,
       external_compensation_cfg_n, internal_compensation_cfg_n, single_ended_cfg, grounded_cfg,
       frontend_active, result_read_busy, nvram_busy, temperature_error_n,
       resistance_meas_busy} <= {v, v, ~v, v, ~v, v, ~v, ~v, v, v, ~v, v};
      converter_overflow_err_n <= (i != 0);
      converter_error_flags <= (i == 2) ? 4'h4 : 4'h0;
      e = {v, 1'b1, v, ~v, v, ~v, v, ~v, (i != 0), (i == 1), v, v, v, 1'b1, ~v, v};
      tick(2);
      chk({4'h0, dsp_in_word[19:4]}, {4'h0, e}, "status");
    end
  endtask : t_status

  task automatic t_gpio();
    @(posedge sys_clk);
    gpio_dir_in <= 4'h5;
    {port_gpio_three_in, port_gpio_two_in, port_gpio_one_in, port_gpio_zero_in} <= 4'hA;
    wr(16'h0035);
    chk({14'h0, port_gpio_five, port_gpio_four, port_gpio_three_out, port_gpio_two_out,
         port_gpio_one_out, port_gpio_zero_out}, 20'h35, "gpio out");
    tick(3);
    chk({16'h0, dsp_in_word[3:0]}, 20'hA, "gpio in");
    chk({16'h0, port_gpio_three_oe, port_gpio_two_oe, port_gpio_one_oe, port_gpio_zero_oe},
        20'hA, "gpio oe");
    @(posedge sys_clk);
    {pulse_out_one_on, pulse_out_one, pulse_out_zero_on, pulse_out_zero} <= 4'hA;
    wr(16'h000C);
    chk({18'h0, port_gpio_three_out, port_gpio_two_out}, 20'h0, "pulse low");
    @(posedge sys_clk);
    {pulse_out_one, pulse_out_zero} <= 2'h3;
    tick(1);
    chk({18'h0, port_gpio_three_out, port_gpio_two_out}, 20'h3, "pulse high");
    @(posedge sys_clk);
    {pulse_out_one_on, pulse_out_zero_on} <= 2'h0;
    wr(16'h0008);
    chk({18'h0, port_gpio_three_out, port_gpio_two_out}, 20'h2, "pulse off");
  endtask : t_gpio

  task automatic t_trig();
    wr(16'h8200);
    chk({18'h0, bandgap_start_pulse, resistance_meas_start}, 20'h3, "trig on");
    tick(1);
    chk({18'h0, bandgap_start_pulse, resistance_meas_start}, 20'h0, "trig off");
  endtask : t_trig

  task automatic t_cap();
    wr(16'h0100);
    chk({19'h0, cap_meas_start}, 20'h1, "cap start");
    @(posedge sys_clk);
    cap_meas_done <= 1'b1;
    @(posedge sys_clk);
    cap_meas_done <= 1'b0;
    tick(0);
    chk({19'h0, cap_meas_blocked}, 20'h1, "blocked");
    wr(16'h0100);
    chk({18'h0, cap_meas_start, cap_meas_blocked}, 20'h1, "refused");
    wr(16'h2000);
    chk({18'h0, cap_converter_reset, cap_meas_blocked}, 20'h2, "cap reset");
    wr(16'h0100);
    chk({19'h0, cap_meas_start}, 20'h1, "start again");
  endtask : t_cap

  task automatic t_irq();
    @(posedge sys_clk);
    irq_on_gpio_four_en <= 1'b1;
    wr(16'h0810);
    chk({17'h0, interrupt_pin_n, port_gpio_four, port_gpio_five}, 20'h0, "irq set");
    tick(1);
    chk({19'h0, dsp_in_word[RD_IRQ_PIN]}, 20'h0, "irq read");
    @(posedge sys_clk);
    i2c_stop <= 1'b1;
    @(posedge sys_clk);
    i2c_stop <= 1'b0;
    tick(0);
    chk({19'h0, interrupt_pin_n}, 20'h1, "stop clear");
    @(posedge sys_clk);
    {irq_on_gpio_five_en, irq_on_gpio_four_en} <= 2'h2;
    wr(16'h0820);
    chk({18'h0, port_gpio_five, port_gpio_four}, 20'h0, "irq five");
    @(posedge sys_clk);
    spi_ssn <= 1'b1;
    tick(5);
    chk({19'h0, interrupt_pin_n}, 20'h1, "ssn clear");
  endtask : t_irq

  task automatic t_guard();
    wr(16'h0040);
    wr(16'h00C0);
    chk({18'h0, watchdog_restart, init_reset}, 20'h2, "watchdog");
    wr(16'h0080);
    wr(16'h00C0);
    chk({18'h0, watchdog_restart, init_reset}, 20'h1, "init");
    wr(16'h00C0);
    chk({18'h0, watchdog_restart, init_reset}, 20'h0, "unarmed");
  endtask : t_guard

  initial begin
    {req, req_data, timer_start_input, irq_bandgap_trigger_cfg_n, cap_bandgap_trigger_cfg_n,
     external_compensation_cfg_n, internal_compensation_cfg_n, single_ended_cfg, grounded_cfg,
     converter_overflow_err_n, converter_error_flags, frontend_active, result_read_busy,
     nvram_busy, temperature_error_n, resistance_meas_busy, cap_meas_done, i2c_stop} = '0;
    {irq_on_gpio_four_en, irq_on_gpio_five_en, gpio_dir_in, pulse_out_zero, pulse_out_zero_on,
     pulse_out_one, pulse_out_one_on, spi_ssn, port_gpio_zero_in, port_gpio_one_in,
     port_gpio_two_in, port_gpio_three_in} = '0;
    rst = 1'b1;
    clk_en = 1'b1;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    t_status();
    t_gpio();
    t_trig();
    t_cap();
    t_irq();
    t_guard();
    report_and_stop();
  end
endmodule : tb_dsp_io_status_control_port
